// >>> dfc_pkg.sv
// Constants, tables and state types for the output function configuration block.
// Assumes a 100 MHz clock and a 12-bit output code.
`default_nettype none
package dfc_pkg;
  localparam int unsigned CLK_NS = 10;
  // Channel 0 and channel 1 configuration register offsets
  localparam logic [7:0] OUTPUT_FUNCTION_CONFIG_AT_18 = 8'h18;
  localparam logic [7:0] OUTPUT_FUNCTION_CONFIG_AT_06 = 8'h06;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] RD_NONE   = 16'h0000;
  // Field positions
  localparam int B_CLR = 15, B_DEFER = 14, B_GROUP = 13, B_GEO = 7;
  localparam int PH_H = 12, PH_L = 11, WV_H = 10, WV_L = 8;
  localparam int STEP_H = 6, STEP_L = 4, INT_H = 3, INT_L = 0;
  localparam int RISE_H = 6, RISE_L = 4, FALL_H = 3, FALL_L = 1;
  localparam logic [1:0] PH_0 = 2'h0, PH_120 = 2'h1, PH_240 = 2'h2, PH_90 = 2'h3;
  localparam logic [2:0] WAVE_TRI = 3'h0, WAVE_SAW = 3'h1, WAVE_INV = 3'h2;
  localparam logic [2:0] WAVE_SINE = 3'h4, WAVE_OFF = 3'h7;
  localparam logic [3:0] INT_NONE = 4'h0;
  localparam logic [11:0] CODE_ZERO = 12'h000, CODE_MID = 12'h800, CODE_ONE = 12'h001;
  localparam int GEO_SHIFT = 5;  // One part in 32, i.e. 3.125 percent
  localparam logic [11:0] STEP_LSB [8] = '{12'h001, 12'h002, 12'h003, 12'h004,
                                          12'h006, 12'h008, 12'h010, 12'h020};
  typedef int unsigned dfc_lin_t [16];
  typedef int unsigned dfc_geo_t [8];
  // Step times in ns
  localparam dfc_lin_t LIN_NS = '{0, 4000, 8000, 12000, 18000, 27040, 40480, 60720, 91120,
                                  136720, 239200, 418640, 732560, 1282000, 2563960, 5127920};
  localparam dfc_geo_t GEO_NS = '{4000, 12000, 27040, 60720, 136720, 418640, 1282000, 5127920};
  // Least time rounds up, never below one cycle
  function automatic dfc_lin_t dfc_lin_cyc();
    dfc_lin_t r;
    for (int i = 0; i < 16; i++) begin
      r[i] = (LIN_NS[i] + CLK_NS - 1) / CLK_NS;
      if (r[i] == 0) r[i] = 1;
    end
    return r;
  endfunction
  function automatic dfc_geo_t dfc_geo_cyc();
    dfc_geo_t r;
    for (int i = 0; i < 8; i++) r[i] = (GEO_NS[i] + CLK_NS - 1) / CLK_NS;
    return r;
  endfunction
  typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_WAVE} dfc_st_t;
  typedef struct packed {
    logic [15:0] cfg;
    logic [11:0] code;
    logic [11:0] pend;
    logic        pend_v;
    logic        up;
    logic [11:0] tgt;
    logic [19:0] cnt;
    dfc_st_t     st;
  } dfc_ch_t;
  typedef struct packed {
    dfc_ch_t [1:0] ch;
    logic          ls1;
    logic          ls2;
    logic          ls3;
    logic [15:0]   rd;
  } dfc_state_t;
endpackage
`default_nettype wire

// >>> dfc_top.sv
// Two-channel output function configuration: clear level, update timing,
// group-write gating, waveform generation and linear or geometric ramps.
// Assumes register writes arrive decoded from the serial host interface.
`timescale 1ns/100ps
`default_nettype none
module dfc_top
  import dfc_pkg::*;
#(
  parameter dfc_lin_t LIN_CYC = dfc_lin_cyc(),
  parameter dfc_geo_t GEO_CYC = dfc_geo_cyc()
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             wr_en,
  input  wire logic [7:0]       wr_addr,
  input  wire logic [15:0]      wr_data,
  input  wire logic [7:0]       rd_addr,
  output logic      [15:0]      rd_data,
  input  wire logic [1:0]       data_wr,
  input  wire logic [1:0][11:0] data_code,
  input  wire logic             bcast_wr,
  input  wire logic [11:0]      bcast_code,
  input  wire logic             load_strobe,
  input  wire logic             load_trig,
  input  wire logic [1:0]       clr,
  input  wire logic [1:0]       ramp_hi_req,
  input  wire logic [1:0]       ramp_lo_req,
  input  wire logic [1:0][11:0] bound_hi,
  input  wire logic [1:0][11:0] bound_lo,
  output logic      [1:0][11:0] out_code
);
  localparam logic [7:0] CFG_ADDR [2] = '{OUTPUT_FUNCTION_CONFIG_AT_18,
                                         OUTPUT_FUNCTION_CONFIG_AT_06};
  dfc_state_t q_r;
  dfc_state_t q_nxt;
  logic       ld_evt;

  // Step reload picks the table by ramp kind and direction
  function automatic logic [19:0] reload(input logic [15:0] cfg, input logic up);
    if (cfg[B_GEO]) begin
      return 20'(GEO_CYC[up ? cfg[RISE_H:RISE_L] : cfg[FALL_H:FALL_L]] - 1);
    end
    return 20'(LIN_CYC[cfg[INT_H:INT_L]] - 1);
  endfunction

  // Falling load strobe, seen after the two-stage synchroniser
  assign ld_evt = q_r.ls3 & ~q_r.ls2;

  // Next state; priority is clear, config, ramp request, data, load, step
  always_comb begin
    dfc_ch_t     c;
    dfc_ch_t     n;
    logic [12:0] sum;
    logic [11:0] d, span, hi_l, lo_l;
    logic        hit, wave_ok, cfg_hit, grp;
    c = '0; n = '0; sum = '0; d = '0; span = '0; hi_l = '0; lo_l = '0;
    hit = 1'b0; wave_ok = 1'b0; cfg_hit = 1'b0; grp = 1'b0;
    q_nxt = q_r;
    q_nxt.ls1 = load_strobe;
    q_nxt.ls2 = q_r.ls1;
    q_nxt.ls3 = q_r.ls2;
    q_nxt.rd = RD_NONE;
    for (int i = 0; i < 2; i++) begin
      c = q_r.ch[i];
      n = c;
      hit = 1'b0;
      cfg_hit = wr_en && (wr_addr == CFG_ADDR[i]);
      grp = bcast_wr && c.cfg[B_GROUP];
      if (rd_addr == CFG_ADDR[i]) q_nxt.rd = c.cfg;
      // Step size: geometric is a fraction of the code, at least one LSB
      if (c.cfg[B_GEO]) begin
        d = ((c.code >> GEO_SHIFT) == CODE_ZERO) ? CODE_ONE : (c.code >> GEO_SHIFT);
      end else begin
        d = STEP_LSB[c.cfg[STEP_H:STEP_L]];
      end
      hi_l = (c.st == ST_WAVE) ? bound_hi[i] : c.tgt;
      lo_l = (c.st == ST_WAVE) ? bound_lo[i] : c.tgt;
      sum = {1'b0, c.code} + {1'b0, d};
      if (clr[i]) begin
        n.code = c.cfg[B_CLR] ? CODE_MID : CODE_ZERO;
        n.st = ST_IDLE;
        n.pend_v = 1'b0;
      end else if (cfg_hit) begin
        n.cfg = wr_data;
        wave_ok = (wr_data[WV_H:WV_L] == WAVE_TRI) || (wr_data[WV_H:WV_L] == WAVE_SAW) ||
                  (wr_data[WV_H:WV_L] == WAVE_INV) || (wr_data[WV_H:WV_L] == WAVE_SINE);
        span = bound_hi[i] - bound_lo[i];
        // Interval zero cannot pace a waveform, so it does not start one
        if (wave_ok && wr_data[INT_H:INT_L] != INT_NONE) begin
          n.st = ST_WAVE;
          case (wr_data[PH_H:PH_L])
            PH_0: begin
              n.code = bound_lo[i];
              n.up = 1'b1;
            end
            PH_120: begin
              n.code = bound_lo[i] + (span >> 1) + (span >> 3) + (span >> 5);
              n.up = 1'b1;
            end
            PH_240: begin
              n.code = bound_hi[i] - (span >> 2) - (span >> 4) - (span >> 6);
              n.up = 1'b0;
            end
            default: begin
              n.code = bound_lo[i] + (span >> 1);
              n.up = 1'b1;
            end
          endcase
          if (wr_data[WV_H:WV_L] == WAVE_SAW) n.up = 1'b1;
          if (wr_data[WV_H:WV_L] == WAVE_INV) n.up = 1'b0;
          n.cnt = reload(wr_data, n.up);
        end else if (c.st == ST_WAVE) begin
          n.st = ST_IDLE;
        end
      end else if (ramp_hi_req[i] || ramp_lo_req[i]) begin
        n.tgt = ramp_hi_req[i] ? bound_hi[i] : bound_lo[i];
        n.up = ramp_hi_req[i];
        if (!c.cfg[B_GEO] && c.cfg[INT_H:INT_L] == INT_NONE) begin
          n.code = n.tgt;
          n.st = ST_IDLE;
        end else begin
          n.st = ST_RAMP;
          n.cnt = reload(c.cfg, n.up);
          if (c.cfg[B_GEO] && ramp_hi_req[i] && c.code == CODE_ZERO) n.code = CODE_ONE;
        end
      end else if (data_wr[i] || grp) begin
        // A load in the same cycle as a deferred write takes the new data
        if (c.cfg[B_DEFER] && !(ld_evt || load_trig)) begin
          n.pend = data_wr[i] ? data_code[i] : bcast_code;
          n.pend_v = 1'b1;
        end else begin
          n.code = data_wr[i] ? data_code[i] : bcast_code;
          n.pend_v = 1'b0;
          n.st = ST_IDLE;
        end
      end else if ((ld_evt || load_trig) && c.pend_v) begin
        n.code = c.pend;
        n.pend_v = 1'b0;
        n.st = ST_IDLE;
      end else if (c.st != ST_IDLE) begin
        if (c.cnt != 20'h0_0000) begin
          n.cnt = c.cnt - 20'h0_0001;
        end else begin
          // Snap to the bound rather than overshoot it
          if (c.up) begin
            hit = (sum >= {1'b0, hi_l});
            n.code = hit ? hi_l : sum[11:0];
          end else begin
            hit = ({1'b0, c.code} <= ({1'b0, lo_l} + {1'b0, d}));
            n.code = hit ? lo_l : (c.code - d);
          end
          if (hit && c.st == ST_RAMP) n.st = ST_IDLE;
          if (hit && c.st == ST_WAVE) begin
            // Sine follows the triangle path: no curve table is held
            case (c.cfg[WV_H:WV_L])
              WAVE_SAW: n.code = lo_l;
              WAVE_INV: n.code = hi_l;
              default:  n.up = ~c.up;
            endcase
          end
          n.cnt = reload(c.cfg, n.up);
        end
      end
      q_nxt.ch[i] = n;
    end
  end

  // One register stage holds all state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
      q_r.ls1 <= 1'b1;
      q_r.ls2 <= 1'b1;
      q_r.ls3 <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rd_data = q_r.rd;
  assign out_code[0] = q_r.ch[0].code;
  assign out_code[1] = q_r.ch[1].code;

  // Checks on channel 0
  dfc_ch_t     c0;
  logic        cfg0, quiet0, step0;
  logic [2:0]  step_f0, rise_f0, fall_f0;
  logic [3:0]  int_f0;
  logic [11:0] gd0, jt0;
  assign c0 = q_r.ch[0];
  assign cfg0 = wr_en && (wr_addr == OUTPUT_FUNCTION_CONFIG_AT_18);
  assign quiet0 = !clr[0] && !cfg0 && !ramp_hi_req[0] && !ramp_lo_req[0] && !data_wr[0] &&
                  !(bcast_wr && c0.cfg[B_GROUP]) && !((ld_evt || load_trig) && c0.pend_v);
  assign step0 = quiet0 && c0.st != ST_IDLE && c0.cnt == 20'h0_0000;
  assign step_f0 = c0.cfg[STEP_H:STEP_L];
  assign rise_f0 = c0.cfg[RISE_H:RISE_L];
  assign fall_f0 = c0.cfg[FALL_H:FALL_L];
  assign int_f0 = c0.cfg[INT_H:INT_L];
  assign gd0 = (c0.code < 12'h0020) ? CODE_ONE : {5'h00, c0.code[11:5]};
  // Jump target of a ramp request; the upper bound wins when both ask
  assign jt0 = ramp_hi_req[0] ? bound_hi[0] : bound_lo[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_clear;
    clr[0] |=> c0.code == (c0.cfg[B_CLR] ? CODE_MID : CODE_ZERO);
  endproperty
  a_clear: assert property (p_clear) else $error("clear level wrong");
  property p_immediate;
    data_wr[0] && !clr[0] && !cfg0 && !ramp_hi_req[0] && !ramp_lo_req[0] && !c0.cfg[B_DEFER]
      |=> c0.code == $past(data_code[0]);
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate update missed");
  property p_deferred;
    data_wr[0] && !clr[0] && !cfg0 && !ramp_hi_req[0] && !ramp_lo_req[0] && c0.cfg[B_DEFER] &&
      !ld_evt && !load_trig |=> $stable(c0.code) && c0.pend_v;
  endproperty
  a_deferred: assert property (p_deferred) else $error("deferred write applied early");
  property p_group_ignored;
    bcast_wr && !c0.cfg[B_GROUP] && quiet0 && c0.st == ST_IDLE |=> $stable(c0.code);
  endproperty
  a_group_ignored: assert property (p_group_ignored) else $error("group write not gated");
  property p_phase0;
    cfg0 && !clr[0] && wr_data[PH_H:PH_L] == PH_0 && wr_data[WV_H:WV_L] == WAVE_TRI &&
      wr_data[INT_H:INT_L] != INT_NONE |=> c0.code == $past(bound_lo[0]) && c0.up;
  endproperty
  a_phase0: assert property (p_phase0) else $error("zero phase start wrong");
  property p_wave_def;
    c0.st == ST_WAVE |-> c0.cfg[WV_H:WV_L] != WAVE_OFF && c0.cfg[INT_H:INT_L] != INT_NONE;
  endproperty
  a_wave_def: assert property (p_wave_def) else $error("waveform runs while disabled");
  property p_jump;
    (ramp_hi_req[0] || ramp_lo_req[0]) && !clr[0] && !cfg0 && !c0.cfg[B_GEO] &&
      c0.cfg[INT_H:INT_L] == INT_NONE |=> c0.code == $past(jt0) && c0.st == ST_IDLE;
  endproperty
  a_jump: assert property (p_jump) else $error("interval zero did not jump");
  property p_lin_step;
    step0 && c0.st == ST_RAMP && !c0.cfg[B_GEO] && c0.up
      |=> c0.code == $past(c0.tgt) || c0.code - $past(c0.code) == STEP_LSB[$past(step_f0)];
  endproperty
  a_lin_step: assert property (p_lin_step) else $error("linear step size wrong");
  property p_lin_time;
    step0 && c0.st == ST_RAMP && !c0.cfg[B_GEO]
      |=> c0.st == ST_IDLE || c0.cnt == 20'(LIN_CYC[$past(int_f0)] - 1);
  endproperty
  a_lin_time: assert property (p_lin_time) else $error("linear step time wrong");
  property p_geo_time;
    step0 && c0.st == ST_RAMP && c0.cfg[B_GEO] |=> c0.st == ST_IDLE ||
      c0.cnt == 20'(GEO_CYC[$past(c0.up) ? $past(rise_f0) : $past(fall_f0)] - 1);
  endproperty
  a_geo_time: assert property (p_geo_time) else $error("geometric step time wrong");
  property p_geo_rise;
    step0 && c0.st == ST_RAMP && c0.cfg[B_GEO] && c0.up
      |=> c0.code == $past(c0.tgt) || c0.code == $past(c0.code) + $past(gd0);
  endproperty
  a_geo_rise: assert property (p_geo_rise) else $error("geometric rise step wrong");
  property p_geo_start;
    ramp_hi_req[0] && !clr[0] && !cfg0 && c0.cfg[B_GEO] && c0.code == CODE_ZERO
      |=> c0.code == CODE_ONE;
  endproperty
  a_geo_start: assert property (p_geo_start) else $error("geometric ramp not from one");

  c_wave: cover property (c0.st == ST_WAVE && step0);
  c_ramp_done: cover property (c0.st == ST_RAMP ##1 c0.st == ST_IDLE);
  c_load: cover property (c0.pend_v && ld_evt);
  c_geo: cover property (step0 && c0.cfg[B_GEO] && !c0.up);
endmodule
`default_nettype wire

// >>> dfc_host.sv
// Host model: writes channel configuration words one at a time.
// Assumes the block samples wr_en on the rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module dfc_host (
  input  wire logic        clk,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [15:0]      wr_data
);
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 16'h0000;
  end
  // One write; undefined shapes and a zero interval under a live shape are never sent
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    if (v[10:8] inside {3'h3, 3'h5, 3'h6}) v[10:8] = 3'h7;
    if (v[10:8] != 3'h7 && v[3:0] == 4'h0) v[10:8] = 3'h7;
    wr_addr = a;
    wr_data = v;
    wr_en   = 1'b1;
    @(posedge clk);
    #1;
    // Released bus shows the inverse so a stale word cannot pass as fresh
    wr_en   = 1'b0;
    wr_addr = ~a;
    wr_data = ~v;
    // Idle edge between writes keeps config stable while its effect starts
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the output function configuration block.
// Assumes the host model drives register writes; this module drives the rest.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dfc_pkg::*;
  // Short step tables keep every ramp within a few thousand cycles
  localparam dfc_lin_t LC = '{1, 2, 3, 4, 5, 6, 7, 8, 2, 3, 4, 5, 6, 7, 8, 9};
  localparam dfc_geo_t GC = '{2, 3, 4, 5, 6, 7, 8, 9};
  localparam int STEPS [8] = '{1, 2, 3, 4, 6, 8, 16, 32};
  localparam logic [2:0] SHAPES [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             wr_en, bcast_wr, load_strobe, load_trig;
  logic [7:0]       wr_addr, rd_addr;
  logic [15:0]      wr_data, rd_data, d;
  logic [1:0]       data_wr, clr, ramp_hi_req, ramp_lo_req;
  logic [1:0][11:0] data_code, bound_hi, bound_lo, out_code;
  logic [11:0]      bcast_code;
  logic [31:0]      rnd = 32'd88916;
  int               mismatches = 0, comparisons = 0, n, p, q;
  int               exp_q [$];

  always #5 clk = ~clk;

  dfc_host u_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  dfc_top #(.LIN_CYC(LC), .GEO_CYC(GC)) u_dfc_top (
    .clk(clk), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .data_wr(data_wr), .data_code(data_code),
    .bcast_wr(bcast_wr), .bcast_code(bcast_code), .load_strobe(load_strobe),
    .load_trig(load_trig), .clr(clr), .ramp_hi_req(ramp_hi_req),
    .ramp_lo_req(ramp_lo_req), .bound_hi(bound_hi), .bound_lo(bound_lo),
    .out_code(out_code));

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Inputs always move 1 ns after the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
  endfunction
  task automatic cfg(input int ch, input logic [15:0] v);
    u_host.wr(ch ? OUTPUT_FUNCTION_CONFIG_AT_06 : OUTPUT_FUNCTION_CONFIG_AT_18, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rd_addr = a;
    tick(1);
    chk(rd_data, exp);
  endtask
  // One-cycle pulse after an idle edge: 0 data, 1 group, 2 clear, 3 trigger, 4 up, 5 down
  task automatic ev(input int k, input int ch, input logic [11:0] v);
    tick(1);
    data_code[ch] = v;
    bcast_code    = v;
    case (k)
      0: data_wr[ch] = 1'b1;
      1: bcast_wr = 1'b1;
      2: clr[ch] = 1'b1;
      3: load_trig = 1'b1;
      4: ramp_hi_req[ch] = 1'b1;
      default: ramp_lo_req[ch] = 1'b1;
    endcase
    tick(1);
    {data_wr, bcast_wr, clr, load_trig, ramp_hi_req, ramp_lo_req} = '0;
  endtask
  // Edges until the channel output moves, bounded
  task automatic wchg(input int ch, output int k);
    logic [11:0] old;
    old = out_code[ch];
    k = 0;
    while (out_code[ch] === old) begin
      tick(1);
      k++;
      if (k > 3000) begin
        mismatches++;
        $display("unexpected at %0t: no change %h %h", $time, old, out_code[ch]);
        end_sim();
      end
    end
  endtask

  initial begin
    {data_wr, bcast_wr, clr, load_trig, ramp_hi_req, ramp_lo_req} = '0;
    {data_code, bound_hi, bound_lo, bcast_code, rd_addr} = '0;
    load_strobe = 1'b1;
    tick(2);
    rst_b = 1'b1;
    tick(3);
    rd(OUTPUT_FUNCTION_CONFIG_AT_18, 16'h0000);
    rd(OUTPUT_FUNCTION_CONFIG_AT_06, 16'h0000);
    u_host.wr(8'h07, 16'hFFFF);
    rd(8'h07, 16'h0000);
    // Random read-back of both channels, generation kept off
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      d = rnd[15:0] | 16'h0700;
      cfg(i % 2, d);
      rd(i % 2 ? OUTPUT_FUNCTION_CONFIG_AT_06 : OUTPUT_FUNCTION_CONFIG_AT_18, d);
    end
    cfg(0, 16'h0700);
    cfg(1, 16'h0700);
    ev(0, 0, 12'h3A5);
    chk(16'(out_code[0]), 16'h03A5);
    ev(1, 0, 12'h111);
    chk({out_code[1][3:0], out_code[0]}, 16'h03A5);
    cfg(1, 16'h2700);
    ev(1, 0, 12'h456);
    chk({out_code[1][3:0], out_code[0]}, 16'h63A5);
    // Deferred writes wait for the trigger bit, then for a falling pin
    cfg(0, 16'h4700);
    ev(0, 0, 12'h0C3);
    chk(16'(out_code[0]), 16'h03A5);
    ev(3, 0, 12'h000);
    chk(16'(out_code[0]), 16'h00C3);
    ev(0, 0, 12'h5A0);
    load_strobe = 1'b0;
    tick(5);
    load_strobe = 1'b1;
    chk(16'(out_code[0]), 16'h05A0);
    for (int b = 0; b < 2; b++) begin
      cfg(0, 16'(b << 15) | 16'h0700);
      ev(0, 0, 12'h123);
      ev(2, 0, 12'h000);
      chk(16'(out_code[0]), b ? 16'h0800 : 16'h0000);
    end
    // Linear ramps: each step size with its own interval, then a jump back
    ev(0, 0, 12'h000);
    bound_hi[0] = 12'h100;
    for (int k = 0; k < 8; k++) begin
      cfg(0, 16'h0700 | 16'(k << 4) | 16'(k + 1));
      ev(4, 0, 12'h000);
      wchg(0, n);
      chk(16'(out_code[0]), 16'(STEPS[k]));
      wchg(0, n);
      chk(16'(out_code[0]), 16'(2 * STEPS[k]));
      chk(16'(n), 16'(LC[k + 1]));
      for (int j = 0; j < 300 && out_code[0] !== 12'h100; j++) wchg(0, n);
      chk(16'(out_code[0]), 16'h0100);
      cfg(0, 16'h0700 | 16'(k << 4));
      ev(5, 0, 12'h000);
      chk(16'(out_code[0]), 16'h0000);
    end
    // Geometric ramps: rise codes 0 to 3 used once, each paired with fall codes 7 down to 4
    bound_hi[0] = 12'h0C0;
    for (int j = 0; j < 4; j++) begin
      cfg(0, 16'h0780 | 16'(j << 4) | 16'((7 - j) << 1));
      bound_lo[0] = 12'h000;
      ev(0, 0, 12'h000);
      // Model of the rise: grow by one part in 32, at least one code, clamp at the bound
      p = 1;
      while (p < 'hC0) begin
        p = p + ((p >> 5) > 0 ? p >> 5 : 1);
        exp_q.push_back(p > 'hC0 ? 'hC0 : p);
      end
      // The start from zero lands on code one at the request edge itself
      ev(4, 0, 12'h000);
      chk(16'(out_code[0]), 16'h0001);
      while (exp_q.size() > 0) begin
        q = exp_q.pop_front();
        wchg(0, n);
        chk(16'(out_code[0]), 16'(q));
        chk(16'(n), 16'(GC[j]));
      end
      p = 'hC0;
      bound_lo[0] = 12'h040;
      ev(5, 0, 12'h000);
      for (int s = 0; s < 200 && p > 'h40; s++) begin
        q = p - ((p >> 5) > 0 ? p >> 5 : 1);
        if (q < 'h40) q = 'h40;
        wchg(0, n);
        chk(16'(out_code[0]), 16'(q));
        chk(16'(n), 16'(GC[7 - j]));
        p = q;
      end
    end
    // Waveforms on alternate channels, so the channel 0 checks see the even-numbered ones
    bound_lo = {2{12'h100}};
    bound_hi = {2{12'h180}};
    for (int w = 0; w < 8; w++) begin
      d = w < 4 ? {5'h00, SHAPES[w], 8'h01} : {3'h0, 2'(w - 4), 3'h0, 8'h01};
      cfg(w % 2, d);
      if (w == 4 || w == 7) chk(16'(out_code[w % 2]), w == 4 ? 16'h0100 : 16'h0140);
      q = 0;
      for (int s = 0; s < 60; s++) begin
        p = int'(out_code[w % 2]);
        tick(1);
        if (out_code[w % 2] !== p[11:0]) q++;
        chk(16'(out_code[w % 2] < 12'h100 || out_code[w % 2] > 12'h180), 16'h0000);
      end
      chk(16'(q > 0), 16'h0001);
      cfg(w % 2, 16'h0700);
      p = int'(out_code[w % 2]);
      tick(8);
      chk(16'(out_code[w % 2]), 16'(p));
    end
    end_sim();
  end
endmodule
`default_nettype wire
